// ### design/mps_consts.svh
// constants of the microstep phase sequencer: offsets, fields, reset values, counts
// assumes it is included by the package and the top module only
//
// Summary of operation
// - mode pins: LL sixteenth, HL half, LH quarter, HH eighth step.
// - unconnected mode pins read low, giving sixteenth-step mode by default.
// - any change of the selected mode restarts the sequence from the initial state.
// - all controls high: step clockwise on step clock when direction low, else counter-clockwise.
// - reset low with standby and enable high holds initial state, ignoring step and direction.
// - enable low with standby high turns every phase output off, high impedance.
// - standby low turns every phase output off and overrides all other controls except a mode change, which still restarts the sequence.
// - initial state commands full current on phase A, zero on phase B.
// - current from first to second output is positive; polarity follows the sign.
// - torque low scales the reference to 25 percent, high to 100 percent.
// - charge ends when sense reaches one fifth of reference, scaled by torque and level.
// - enable low still advances the phase; outputs resume at the advanced phase.
// - after reset release the next rising step edge applies the step after initial.
// - reset released while step clock high applies the following step at once.
// - levels come from a 17-entry quarter table; coarser modes skip entries.
// - chopping period is eight oscillator cycles, the last one fast decay.
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH

`define MPS_ADDR_W        4
`define MPS_REG_CTRL      4'h0
`define MPS_REG_STATUS    4'h4
`define MPS_OSC_DIV_RST   16'h0028
`define MPS_OSC_DIV_W     16
`define MPS_CHOP_CYCLES   3'h7
`define MPS_IDX_W         6
`define MPS_INC_SIXTEENTH 6'h01
`define MPS_INC_EIGHTH    6'h02
`define MPS_INC_QUARTER   6'h04
`define MPS_INC_HALF      6'h08
`define MPS_TQ_LOW        7'h19
`define MPS_TQ_HIGH       7'h64
`define MPS_SENSE_SCALE   16'hC350
`define MPS_ST_IDX_LSB    0
`define MPS_ST_MODE_LSB   8
`define MPS_ST_HOME_BIT   12
`define MPS_ST_DRIVE_BIT  13

`endif

// ### design/mps_pkg.sv
// types of the microstep phase sequencer: modes, chopper states, bus carriers
// assumes the constants header sits beside it
`include "mps_consts.svh"
package mps_pkg;

  typedef enum logic [3:0] {
    MPS_SIXTEENTH = 4'b0001,
    MPS_EIGHTH    = 4'b0010,
    MPS_QUARTER   = 4'b0100,
    MPS_HALF      = 4'b1000
  } mps_mode_e;

  typedef enum logic [3:0] {
    MPS_OFF    = 4'b0001,
    MPS_CHARGE = 4'b0010,
    MPS_SLOW   = 4'b0100,
    MPS_FAST   = 4'b1000
  } mps_chop_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [`MPS_ADDR_W-1:0] adr;
    logic [31:0] dat;
  } mps_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } mps_wb_rsp_s;

endpackage : mps_pkg

// ### design/mps_top.sv
// microstep phase sequencer: step/direction decoder, phase table, chopper, wishbone slave
// assumes all motor control pins and sense codes are asynchronous to clk_i
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "mps_consts.svh"
module mps_top (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  mps_pkg::mps_wb_req_s wb_req_i,
  output mps_pkg::mps_wb_rsp_s wb_rsp_o,
  input  wire logic          step_clk_i,
  input  wire logic          rotation_dir_i,
  input  wire logic          reset_n_i,
  input  wire logic          enable_i,
  input  wire logic          sleep_n_i,
  input  wire logic          step_mode_sel_lo_i,
  input  wire logic          step_mode_sel_hi_i,
  input  wire logic          torque_sel_i,
  input  wire logic [7:0]    sense_a_i,
  input  wire logic [7:0]    sense_b_i,
  input  wire logic [7:0]    vref_i,
  output logic               phase_a_out_p_o,
  output logic               phase_a_out_p_oe_o,
  output logic               phase_a_out_n_o,
  output logic               phase_a_out_n_oe_o,
  output logic               phase_b_out_p_o,
  output logic               phase_b_out_p_oe_o,
  output logic               phase_b_out_n_o,
  output logic               phase_b_out_n_oe_o,
  output logic               home_flag_n_o,
  output logic               home_flag_n_oe_o
);
  import mps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic mps_mode_e mode_decode(input logic lo, input logic hi);
    mps_mode_e m;
    m = MPS_SIXTEENTH;
    if (!lo && !hi)    m = MPS_SIXTEENTH;
    else if (lo && !hi) m = MPS_HALF;
    else if (!lo && hi) m = MPS_QUARTER;
    else               m = MPS_EIGHTH;
    return m;
  endfunction : mode_decode

  // quarter-cycle cosine table, percent
  function automatic logic [6:0] level_lut(input logic [4:0] p);
    logic [6:0] v;
    v = 7'h00;
    case (p)
      5'd0:  v = 7'd100;
      5'd1:  v = 7'd100;
      5'd2:  v = 7'd98;
      5'd3:  v = 7'd96;
      5'd4:  v = 7'd92;
      5'd5:  v = 7'd88;
      5'd6:  v = 7'd83;
      5'd7:  v = 7'd77;
      5'd8:  v = 7'd71;
      5'd9:  v = 7'd63;
      5'd10: v = 7'd56;
      5'd11: v = 7'd47;
      5'd12: v = 7'd38;
      5'd13: v = 7'd29;
      5'd14: v = 7'd20;
      5'd15: v = 7'd10;
      default: v = 7'd0;
    endcase
    return v;
  endfunction : level_lut

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: pins are asynchronous, two flops before any logic

  localparam int SYNC_W = 32;
  logic [SYNC_W-1:0] sync_1;
  logic [SYNC_W-1:0] sync_2;
  logic              step_q;

  // sense codes are slow analog conversions; a torn sample only shifts one decision
  always_ff @(posedge clk_i) begin
    sync_1 <= {sense_b_i, sense_a_i, vref_i, step_clk_i, rotation_dir_i, reset_n_i,
               enable_i, sleep_n_i, step_mode_sel_lo_i, step_mode_sel_hi_i, torque_sel_i};
    sync_2 <= sync_1;
  end

  logic       step_s;
  logic       dir_s;
  logic       reset_n_s;
  logic       enable_s;
  logic       sleep_n_s;
  logic       mode_lo_s;
  logic       mode_hi_s;
  logic       torque_s;
  logic [7:0] vref_s;
  logic [7:0] sense_s [2];

  assign {sense_s[1], sense_s[0], vref_s, step_s, dir_s, reset_n_s, enable_s, sleep_n_s,
          mode_lo_s, mode_hi_s, torque_s} = sync_2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_q <= 1'b0;
    end else begin
      step_q <= step_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase index sequencer

  mps_mode_e              mode_now;
  mps_mode_e              mode_q;
  logic [`MPS_IDX_W-1:0]  idx;
  logic [`MPS_IDX_W-1:0]  inc;
  logic                   pending;
  logic                   step_rise;

  assign mode_now  = mode_decode(mode_lo_s, mode_hi_s);
  assign step_rise = step_s && !step_q;

  always_comb begin
    inc = `MPS_INC_SIXTEENTH;
    case (mode_q)
      MPS_SIXTEENTH: inc = `MPS_INC_SIXTEENTH;
      MPS_EIGHTH:    inc = `MPS_INC_EIGHTH;
      MPS_QUARTER:   inc = `MPS_INC_QUARTER;
      MPS_HALF:      inc = `MPS_INC_HALF;
      default:       inc = `MPS_INC_SIXTEENTH;
    endcase
  end

  // enable is not looked at here, so the index keeps moving while outputs are off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx     <= '0;
      pending <= 1'b0;
      mode_q  <= MPS_SIXTEENTH;
    end else begin
      mode_q <= mode_now;
      if (mode_now != mode_q) begin
        idx     <= '0;
        pending <= 1'b0;
      end else if (!sleep_n_s) begin
        idx <= idx;
      end else if (!reset_n_s) begin
        idx     <= '0;
        pending <= 1'b1;
      end else if (step_rise || (pending && step_s)) begin
        // modulo 64 wrap is the natural overflow of the index width
        idx     <= dir_s ? idx - inc : idx + inc;
        pending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase levels and signs

  logic [4:0] fold;
  logic [6:0] lvl [2];
  logic       neg [2];
  logic [6:0] tq;

  assign fold   = idx[4] ? 5'd16 - {1'b0, idx[3:0]} : {1'b0, idx[3:0]};
  assign lvl[0] = level_lut(fold);
  assign lvl[1] = level_lut(5'd16 - fold);
  assign neg[0] = idx[5] ^ idx[4];
  assign neg[1] = idx[5];
  assign tq     = torque_s ? `MPS_TQ_HIGH : `MPS_TQ_LOW;

  ////////////////////////////////////////////////////////////////////////////
  // chopping oscillator

  logic [`MPS_OSC_DIV_W-1:0] osc_div;
  logic [`MPS_OSC_DIV_W-1:0] div_cnt;
  logic [2:0]                osc_cnt;
  logic                      osc_tick;

  assign osc_tick = (div_cnt + 16'h0001 >= osc_div);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= '0;
      osc_cnt <= 3'h0;
    end else if (osc_tick) begin
      div_cnt <= '0;
      osc_cnt <= osc_cnt + 3'h1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-phase chopper and bridge drive

  logic [3:0] pin_o;
  logic [3:0] pin_oe;
  logic       drive_on;

  assign drive_on = sleep_n_s && enable_s;

  for (genvar g = 0; g < 2; g++) begin : g_phase
    logic      trip;
    logic      reach;
    mps_chop_e st;

    // sense * 5 * 100 * 100 against vref * level * torque, avoiding a divider
    assign reach = (24'(sense_s[g]) * 24'(`MPS_SENSE_SCALE)) >=
                   (24'(vref_s) * 24'(lvl[g]) * 24'(tq));

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        trip <= 1'b0;
      end else if (reach) begin
        // set wins: a trip in the last cycle carries over, so the next period skips charge
        trip <= 1'b1;
      end else if (osc_tick && osc_cnt == `MPS_CHOP_CYCLES) begin
        trip <= 1'b0;
      end
    end

    always_comb begin
      st = MPS_OFF;
      if (!drive_on)                        st = MPS_OFF;
      else if (osc_cnt == `MPS_CHOP_CYCLES) st = MPS_FAST;
      else if (!trip && !reach)             st = MPS_CHARGE;
      else                                  st = MPS_SLOW;
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pin_o[2*g]    <= 1'b0;
        pin_o[2*g+1]  <= 1'b0;
        pin_oe[2*g]   <= 1'b0;
        pin_oe[2*g+1] <= 1'b0;
      end else begin
        pin_oe[2*g]   <= (st != MPS_OFF);
        pin_oe[2*g+1] <= (st != MPS_OFF);
        case (st)
          MPS_CHARGE: begin
            pin_o[2*g]   <= !neg[g];
            pin_o[2*g+1] <= neg[g];
          end
          MPS_FAST: begin
            pin_o[2*g]   <= neg[g];
            pin_o[2*g+1] <= !neg[g];
          end
          default: begin
            pin_o[2*g]   <= 1'b0;
            pin_o[2*g+1] <= 1'b0;
          end
        endcase
      end
    end
  end

  assign phase_a_out_p_o    = pin_o[0];
  assign phase_a_out_n_o    = pin_o[1];
  assign phase_b_out_p_o    = pin_o[2];
  assign phase_b_out_n_o    = pin_o[3];
  assign phase_a_out_p_oe_o = pin_oe[0];
  assign phase_a_out_n_oe_o = pin_oe[1];
  assign phase_b_out_p_oe_o = pin_oe[2];
  assign phase_b_out_n_oe_o = pin_oe[3];

  ////////////////////////////////////////////////////////////////////////////
  // home flag, open drain

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      home_flag_n_o    <= 1'b0;
      home_flag_n_oe_o <= 1'b0;
    end else begin
      home_flag_n_o    <= 1'b0;
      home_flag_n_oe_o <= (idx == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, unmapped reads return zero

  logic bus_req;
  assign bus_req = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_div <= `MPS_OSC_DIV_RST;
    end else if (wb_req_i.cyc && wb_req_i.stb && wb_rsp_o.ack && wb_req_i.we &&
                 wb_req_i.adr == `MPS_REG_CTRL) begin
      // write lands at the edge where the master samples ack, never earlier
      if (wb_req_i.sel[0]) osc_div[7:0]  <= wb_req_i.dat[7:0];
      if (wb_req_i.sel[1]) osc_div[15:8] <= wb_req_i.dat[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_rsp_o <= '0;
    end else begin
      wb_rsp_o.ack <= bus_req;
      wb_rsp_o.dat <= 32'h0000_0000;
      if (bus_req && !wb_req_i.we) begin
        if (wb_req_i.adr == `MPS_REG_CTRL) begin
          wb_rsp_o.dat <= {16'h0000, osc_div};
        end else if (wb_req_i.adr == `MPS_REG_STATUS) begin
          wb_rsp_o.dat[`MPS_ST_IDX_LSB +: 6]  <= idx;
          wb_rsp_o.dat[`MPS_ST_MODE_LSB +: 4] <= mode_q;
          wb_rsp_o.dat[`MPS_ST_HOME_BIT]      <= (idx == '0);
          wb_rsp_o.dat[`MPS_ST_DRIVE_BIT]     <= drive_on;
        end
      end
    end
  end

endmodule : mps_top

// ### dv/mps_ctl_model.sv
// controller model: bursts of step clock pulses on request
// assumes the bench asks for a burst and waits for busy_o low
`timescale 1ns/1ps
module mps_ctl_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] n_i,
  input  wire logic [7:0] half_i,
  output logic            step_clk_o,
  output logic            busy_o
);
  logic [7:0] cnt = 8'h00;
  logic [7:0] ph  = 8'h00;
  logic       lvl = 1'b0;
  wire logic  flip = (ph == half_i - 8'h01);
  ////////////////////////////////////////////////////////////////
  // clock stands low between bursts; levels stay put meanwhile
  always_ff @(posedge clk_i) begin
    if (start_i) begin
      cnt <= n_i;
      ph  <= 8'h00;
      lvl <= 1'b0;
    end else if (cnt != 8'h00) begin
      ph <= flip ? 8'h00 : ph + 8'h01;
      if (flip) begin
        lvl <= ~lvl;
        if (lvl) begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
  assign step_clk_o = lvl;
  assign busy_o     = (cnt != 8'h00);
endmodule : mps_ctl_model

// ### dv/mps_top_asserts.sv
// checker: bus answer and pin states of the sequencer
// assumes bind onto mps_top; phase pin changes show 3 clocks late, the home flag 4
`timescale 1ns/1ps
module mps_top_asserts (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input mps_pkg::mps_wb_req_s wb_req_i,
  input mps_pkg::mps_wb_rsp_s wb_rsp_o,
  input wire logic            reset_n_i,
  input wire logic            enable_i,
  input wire logic            sleep_n_i,
  input wire logic            phase_a_out_p_o,
  input wire logic            phase_a_out_p_oe_o,
  input wire logic            phase_a_out_n_o,
  input wire logic            phase_a_out_n_oe_o,
  input wire logic            phase_b_out_p_o,
  input wire logic            phase_b_out_p_oe_o,
  input wire logic            phase_b_out_n_o,
  input wire logic            phase_b_out_n_oe_o,
  input wire logic            home_flag_n_o,
  input wire logic            home_flag_n_oe_o
);
  import mps_pkg::*;
  wire logic oe = phase_a_out_p_oe_o | phase_a_out_n_oe_o
                | phase_b_out_p_oe_o | phase_b_out_n_oe_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // one cycle of margin past the synchroniser and output delay in s_hold; none in s_sleep and s_off
  sequence s_sleep; (!sleep_n_i) [*4]; endsequence
  sequence s_off; (!enable_i) [*4]; endsequence
  sequence s_hold; (!reset_n_i && sleep_n_i) [*6]; endsequence
  sequence s_req; wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack; endsequence
  AST_SLEEP_OFF: assert property (s_sleep |-> !oe)
    else $error("pins driven in standby");
  AST_ENABLE_OFF: assert property (s_off |-> !oe)
    else $error("pins driven while disabled");
  AST_HOME_INIT: assert property (s_hold |-> home_flag_n_oe_o)
    else $error("home flag released while held");
  AST_HOME_OD: assert property (home_flag_n_o == 1'b0)
    else $error("home flag driven high");
  AST_A_BRIDGE: assert property (!(phase_a_out_p_o && phase_a_out_n_o))
    else $error("phase a both sides high");
  AST_B_BRIDGE: assert property (!(phase_b_out_p_o && phase_b_out_n_o))
    else $error("phase b both sides high");
  AST_ACK_NEXT: assert property (s_req |=> wb_rsp_o.ack)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
    else $error("read data outside ack");
endmodule : mps_top_asserts
bind mps_top mps_top_asserts u_chk (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .reset_n_i,
  .enable_i, .sleep_n_i, .phase_a_out_p_o, .phase_a_out_p_oe_o, .phase_a_out_n_o,
  .phase_a_out_n_oe_o, .phase_b_out_p_o, .phase_b_out_p_oe_o, .phase_b_out_n_o,
  .phase_b_out_n_oe_o, .home_flag_n_o, .home_flag_n_oe_o);

// ### dv/mps_top_tb_top.sv
// self-checking bench of the microstep phase sequencer
// assumes mps_top, the controller model and the bound checker
`timescale 1ns/1ps
module mps_top_tb_top;
  import mps_pkg::*;
  typedef struct packed {
    logic [1:0] m;
    logic       d;
    logic [7:0] n;
    logic [3:0] md;
  } mps_row_s;
  // md doubles as the index increment of the mode
  localparam mps_row_s ROWS [4] = '{'{2'h0, 1'h0, 8'h03, 4'h1}, '{2'h1, 1'h0, 8'h09, 4'h8},
                                    '{2'h2, 1'h1, 8'h02, 4'h4}, '{2'h3, 1'h1, 8'h01, 4'h2}};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  mps_wb_req_s wb_req_i = '0;
  mps_wb_rsp_s wb_rsp_o;
  logic        step_clk_i, busy, start = 1'b0;
  logic        rotation_dir_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        enable_i = 1'b1;
  logic        sleep_n_i = 1'b1;
  logic        step_mode_sel_lo_i = 1'b0;
  logic        step_mode_sel_hi_i = 1'b0;
  logic        torque_sel_i = 1'b0;
  logic [7:0]  n = 8'h00;
  logic [7:0]  half = 8'h10;
  logic [7:0]  sense_a_i = 8'h00;
  wire  [7:0]  sense_b_i = 8'h00;
  wire  [7:0]  vref_i = 8'h80;
  logic        phase_a_out_p_o, phase_a_out_p_oe_o, phase_a_out_n_o, phase_a_out_n_oe_o;
  logic        phase_b_out_p_o, phase_b_out_p_oe_o, phase_b_out_n_o, phase_b_out_n_oe_o;
  logic        home_flag_n_o, home_flag_n_oe_o;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          pa, pb;
  logic [31:0] d;
  logic [5:0]  e;
  wire         any_oe = phase_a_out_p_oe_o | phase_a_out_n_oe_o
                      | phase_b_out_p_oe_o | phase_b_out_n_oe_o;
  mps_top dut (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .step_clk_i, .rotation_dir_i, .reset_n_i,
    .enable_i, .sleep_n_i, .step_mode_sel_lo_i, .step_mode_sel_hi_i, .torque_sel_i, .sense_a_i,
    .sense_b_i, .vref_i, .phase_a_out_p_o, .phase_a_out_p_oe_o, .phase_a_out_n_o,
    .phase_a_out_n_oe_o, .phase_b_out_p_o, .phase_b_out_p_oe_o, .phase_b_out_n_o,
    .phase_b_out_n_oe_o, .home_flag_n_o, .home_flag_n_oe_o);
  mps_ctl_model u_ctl (.clk_i, .start_i(start), .n_i(n), .half_i(half),
    .step_clk_o(step_clk_i), .busy_o(busy));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    samples_checked++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    wb_req_i <= '{1'b1, 1'b1, w, 4'hF, a, wd};
    @(posedge clk_i);
    while (wb_rsp_o.ack !== 1'b1) @(posedge clk_i);
    d = wb_rsp_o.dat;
    wb_req_i <= '0;
  endtask : wb
  task automatic kick(input logic [7:0] k, input logic [7:0] h);
    @(posedge clk_i);
    n <= k;
    half <= h;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
  endtask : kick
  // idle until the burst ends, then let the 4-edge step latency pass
  task automatic fin;
    @(posedge clk_i);
    while (busy) @(posedge clk_i);
    repeat (6) @(posedge clk_i);
  endtask : fin
  // one chopping period is 16 clocks at divider 2
  task automatic cnt16;
    pa = 0;
    pb = 0;
    repeat (16) begin
      @(posedge clk_i);
      pa += phase_a_out_p_o;
      pb += phase_b_out_p_o;
    end
  endtask : cnt16
  task automatic stop_test;
    $display("compares %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", d[15:0], 16'h0028);
    wb(1'b0, 4'h4, 32'h0);
    chk("mode reset", d[11:8], 4'h1);
    chk("home reset", d[12], 1'b1);
    wb(1'b0, 4'h8, 32'h0);
    chk("unmapped", d[15:0], 16'h0000);
    wb(1'b1, 4'h0, 32'h2);
    wb(1'b0, 4'h0, 32'h0);
    chk("ctrl rw", d[15:0], 16'h0002);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      reset_n_i <= 1'b0;
      // mode pins move only once the home flag shows the initial state
      repeat (6) @(posedge clk_i);
      {step_mode_sel_hi_i, step_mode_sel_lo_i} <= ROWS[i].m;
      rotation_dir_i <= ROWS[i].d;
      repeat (6) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk("home before step", home_flag_n_oe_o, 1'b1);
      kick(ROWS[i].n, 8'h10);
      fin();
      wb(1'b0, 4'h4, 32'h0);
      e = 6'(ROWS[i].n * ROWS[i].md);
      if (ROWS[i].d) e = 6'h00 - e;
      chk("index", d[5:0], e);
      chk("mode", d[11:8], ROWS[i].md);
      chk("home", d[12], e == 6'h00);
      cnt16();
      chk("a charge", 16'(pa), (e >= 6'h11 && e <= 6'h2F) ? 16'h2 : 16'hE);
      chk("b charge", 16'(pb), e[5] ? 16'h2 : 16'hE);
    end
    $display("test step rows done");
    {step_mode_sel_hi_i, step_mode_sel_lo_i} <= 2'h0;
    rotation_dir_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(1'b0, 4'h4, 32'h0);
    chk("mode change index", d[5:0], 6'h00);
    chk("mode change home", home_flag_n_oe_o, 1'b1);
    $display("test mode change done");
    enable_i <= 1'b0;
    torque_sel_i <= 1'b1;
    kick(8'h02, 8'h10);
    fin();
    chk("disabled pins", any_oe, 1'b0);
    wb(1'b0, 4'h4, 32'h0);
    chk("disabled index", d[5:0], 6'h02);
    enable_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("resumed pins", any_oe, 1'b1);
    $display("test enable done");
    sleep_n_i <= 1'b0;
    kick(8'h02, 8'h10);
    fin();
    chk("standby pins", any_oe, 1'b0);
    wb(1'b0, 4'h4, 32'h0);
    chk("standby index", d[5:0], 6'h02);
    sleep_n_i <= 1'b1;
    $display("test standby done");
    reset_n_i <= 1'b0;
    kick(8'h02, 8'h10);
    fin();
    wb(1'b0, 4'h4, 32'h0);
    chk("held index", d[5:0], 6'h00);
    kick(8'h01, 8'h10);
    // release while the single step pulse stands high
    repeat (24) @(posedge clk_i);
    reset_n_i <= 1'b1;
    fin();
    wb(1'b0, 4'h4, 32'h0);
    chk("release high step", d[5:0], 6'h01);
    $display("test reset release done");
    // index 1: phase a at full level, torque still high from the enable test
    sense_a_i <= 8'h0A;
    repeat (20) @(posedge clk_i);
    cnt16();
    chk("sense below full", 16'(pa), 16'h000E);
    torque_sel_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    cnt16();
    chk("sense over quarter", 16'(pa), 16'h0000);
    $display("test chopper done");
    stop_test();
  end
endmodule : mps_top_tb_top
